// [inc/pm_map.svh]
// Purpose: command codes, field positions, reset values and timing
// Assumes: 40 MHz module controller clock
// Notes: limit words are kept in the encoding that the host reads back
`ifndef PM_MAP_SVH
`define PM_MAP_SVH

// command codes
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_RUN_CONTROL 8'h01
`define CMD_GATING 8'h02
`define CMD_NV_RESTORE 8'h12
`define CMD_NV_STORE 8'h15
`define CMD_OV_LIMIT 8'h40
`define CMD_OV_RESPONSE 8'h41
`define CMD_OC_LIMIT 8'h46
`define CMD_OC_RESPONSE 8'h47
`define CMD_OT_LIMIT 8'h4f
`define CMD_FW_REV 8'h9b

// transaction kinds on the command port
`define KIND_READ 2'h0
`define KIND_WRITE 2'h1
`define KIND_SEND 2'h2

// byte counts returned with a read
`define COUNT_NONE 8'h00
`define COUNT_BYTE 8'h01
`define COUNT_WORD 8'h02
`define COUNT_FW 8'h02

// run control fields
`define RUN_ON_BIT 7
`define SRC_HI 5
`define SRC_LO 4
`define SRC_BAD 2'h3
`define RUN_RST_ON 1'b1
`define RUN_RST_SRC 2'h0

// power-up gating readback, bits 4 and 3 fixed at one
`define GATING_VALUE 16'h0018

// response fields
`define RSP_ACT_HI 7
`define RSP_ACT_LO 6
`define RSP_RTY_HI 5
`define RSP_RTY_LO 3
`define OV_ACTION 2'h2
`define OC_ACTION 2'h3
`define RETRY_LATCH 3'h0
`define RETRY_CONT 3'h7
`define OV_RETRY_RST 1'b0
`define OC_RETRY_RST 1'b1

// limit words: output voltage exponent -10, current -2, temperature -1
`define OV_LIM_RST 16'h3600
`define OV_LIM_MIN 16'h34cd
`define OV_LIM_MAX 16'h3800
`define OC_LIM_RST 16'hf12c
`define OC_LIM_MIN 16'hf0ac
`define OC_LIM_MAX 16'hf140
`define OT_LIM_RST 16'hf90e
`define OT_LIM_MIN 16'hf8f0
`define OT_LIM_MAX 16'hf918

// fault flag positions
`define FLT_OV 0
`define FLT_OC 1
`define FLT_OT 2

// timing
`define CLK_MHZ 40
`define RETRY_TIME_US 1000

`endif

// [inc/pm_pkg.sv]
// Purpose: shared types of the command register block
// Assumes: nothing
// Notes: state of each module is one packed struct
package pm_pkg;

  typedef enum logic [1:0] {RS_RUN, RS_LATCHED, RS_WAIT} retry_state_e;

  typedef struct packed {
    retry_state_e state;
    logic [31:0] cnt;
    logic hold_off;
  } retry_s;

  typedef struct packed {
    logic run_on;
    logic [1:0] src;
    logic [15:0] ov_lim;
    logic [15:0] oc_lim;
    logic [15:0] ot_lim;
    logic ov_retry;
    logic oc_retry;
    logic [2:0] flags;
    logic nv_locked;
    logic ctl_s1;
    logic ctl_s2;
    logic [2:0] flt_s1;
    logic [2:0] flt_s2;
    logic seen_off;
    logic out_on;
    logic rd_valid;
    logic [15:0] rd_data;
    logic [7:0] rd_count;
  } bank_s;

endpackage : pm_pkg

// [design/restart_ctrl.sv]
// Purpose: shutdown and restart sequencing for one protection
// Assumes: fault is already synchronised to clk
// Notes: hold_off keeps the converter down while high
`timescale 1ns/1ps
`include "pm_map.svh"

module restart_ctrl #(
  parameter int unsigned RETRY_CYCLES = `RETRY_TIME_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic fault,
  input wire logic retry_on,
  input wire logic run_cmd,
  input wire logic cmd_off,
  output logic hold_off
);

  pm_pkg::retry_s st;
  pm_pkg::retry_s next_st;
  localparam logic [31:0] LAST = 32'(RETRY_CYCLES - 1);

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // shut on fault, then latch or count up to LAST before a fresh attempt
  always_comb begin
    next_st = st;
    case (st.state)
      pm_pkg::RS_RUN: begin
        if (fault && !cmd_off) begin
          next_st.state = retry_on ? pm_pkg::RS_WAIT : pm_pkg::RS_LATCHED;
          next_st.cnt = 32'h0;
        end
      end
      pm_pkg::RS_LATCHED: begin
        if (run_cmd) begin // [R19]
          next_st.state = pm_pkg::RS_RUN;
        end
      end
      pm_pkg::RS_WAIT: begin
        if (cmd_off) begin // [R20]
          next_st.state = pm_pkg::RS_RUN;
        end else if (st.cnt == LAST) begin // [R20]
          next_st.state = pm_pkg::RS_RUN;
        end else begin
          next_st.cnt = st.cnt + 32'h1;
        end
      end
      default: begin
        next_st.state = pm_pkg::RS_LATCHED;
      end
    endcase
    next_st.hold_off = (next_st.state != pm_pkg::RS_RUN);
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{state: pm_pkg::RS_RUN, cnt: 32'h0, hold_off: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign hold_off = st.hold_off;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  latch_holds_a: assert property (@(posedge clk) // [R19]
    disable iff (!reset_n)
    (st.state == pm_pkg::RS_LATCHED && !run_cmd) |=> hold_off)
    else $error("latched shutdown released without run command");

  retry_ends_a: assert property (@(posedge clk) disable iff (!reset_n) // [R20]
    (st.state == pm_pkg::RS_WAIT && st.cnt == LAST && !cmd_off)
      |=> !hold_off)
    else $error("continuous retry did not attempt restart");

endmodule : restart_ctrl

// [design/pm_cmd_bank.sv]
// Contract
// (R1) an out-of-range limit write stores the range minimum instead
// (R2) output overvoltage limit range is 13.2 V to 14 V
// (R3) output overcurrent limit range is 43 A to 80 A
// (R4) over-temperature limit range is 120 C to 140 C
// (R5) host encodes new limits with the exponent read back first
// (R6) any access to nonvolatile commands shuts output until power cycle
// (R7) the nonvolatile commands are codes 0x12 and 0x15
// (R8) fault bits stay set until remote off-on, clear command, power loss
// (R9) send byte 0x03 clears every set fault bit; a bit whose fault input is still high stays set
// (R10) firmware revision read returns a block of two bytes
// (R11) run bit 7 turns output on or off, default on; bit 6 unused
// (R12) bits 5:4 pick nominal, margin low or margin high; default nominal
// (R13) gating bit 4 waits for control pin and run command, fixed at one
// (R14) gating bit 3 waits for run command, fixed at one
// (R15) gating bit 2 and bits 1:0, 7:5 are unsupported, read zero
// (R16) overvoltage response action 10 shuts down with retry policy
// (R17) overvoltage retry defaults to latch-off; delay field unused
// (R18) overcurrent action 11 shuts down, default retry continuous
// (R19) latch-off holds the output down until reset or run command
// (R20) continuous retry restarts repeatedly until commanded off
// (R21) reserved bits ignore writes and read as zero
// (R22) unsupported field encodings leave the stored value in effect
//
// Purpose: command registers, limit clamping and sticky fault status
// Assumes: command port is driven by the bus layer on clk; reset_n is
//          the input power cycle
// Notes: fault and control pin inputs are asynchronous and synchronised
`timescale 1ns/1ps
`include "pm_map.svh"

module pm_cmd_bank #(
  parameter int unsigned RETRY_CYCLES = `RETRY_TIME_US * `CLK_MHZ,
  parameter logic [15:0] FW_REVISION = 16'h3130 // arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_strobe,
  input wire logic [1:0] cmd_kind,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic remote_on_pin,
  input wire logic ov_fault_pin,
  input wire logic oc_fault_pin,
  input wire logic ot_fault_pin,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic [7:0] rd_count,
  output logic output_on,
  output logic [1:0] setpoint_sel,
  output logic [2:0] fault_flags,
  output logic nv_locked
);

  pm_pkg::bank_s st;
  pm_pkg::bank_s next_st;
  logic [2:0] hold;
  logic wr;
  logic rd;
  logic clr_cmd;
  logic clr_remote;
  logic clr_any;
  logic run_cmd;
  logic cmd_off;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // keep a limit word in range, else fall back to the minimum
  function automatic logic [15:0] clamp(input logic [15:0] val,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    if (val < lo || val > hi) begin
      clamp = lo; // [R1]
    end else begin
      clamp = val;
    end
  endfunction : clamp

  // response readback from action and stored retry choice
  function automatic logic [15:0] rsp_word(input logic [1:0] act,
                                           input logic cont);
    rsp_word = {8'h00, act, cont ? `RETRY_CONT : `RETRY_LATCH, 3'h0};
  endfunction : rsp_word

  // retry field write, unsupported codes keep the old choice
  function automatic logic rsp_retry(input logic [7:0] w,
                                     input logic [1:0] act,
                                     input logic old);
    logic [2:0] r;
    r = w[`RSP_RTY_HI:`RSP_RTY_LO];
    if (w[`RSP_ACT_HI:`RSP_ACT_LO] != act) begin
      rsp_retry = old; // [R22]
    end else if (r == `RETRY_CONT) begin
      rsp_retry = 1'b1;
    end else if (r == `RETRY_LATCH) begin
      rsp_retry = 1'b0;
    end else begin
      rsp_retry = old; // [R22]
    end
  endfunction : rsp_retry

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // strobe qualifiers and the clear events
  assign wr = cmd_strobe && (cmd_kind == `KIND_WRITE);
  assign rd = cmd_strobe && (cmd_kind == `KIND_READ);
  assign clr_cmd = cmd_strobe && (cmd_kind == `KIND_SEND) &&
                   (cmd_code == `CMD_CLEAR_FAULTS); // [R9]
  assign clr_remote = st.seen_off && st.ctl_s2; // [R8]
  assign clr_any = clr_cmd || clr_remote;
  assign run_cmd = wr && (cmd_code == `CMD_RUN_CONTROL);
  assign cmd_off = !st.run_on || !st.ctl_s2;

  // ----------------------------------------
  // restart sequencing per protection
  // ----------------------------------------
  restart_ctrl #(.RETRY_CYCLES(RETRY_CYCLES)) ov_restart (
    .clk(clk),
    .reset_n(reset_n),
    .fault(st.flt_s2[`FLT_OV]),
    .retry_on(st.ov_retry), // [R16]
    .run_cmd(run_cmd),
    .cmd_off(cmd_off),
    .hold_off(hold[`FLT_OV])
  );

  restart_ctrl #(.RETRY_CYCLES(RETRY_CYCLES)) oc_restart (
    .clk(clk),
    .reset_n(reset_n),
    .fault(st.flt_s2[`FLT_OC]),
    .retry_on(st.oc_retry), // [R18]
    .run_cmd(run_cmd),
    .cmd_off(cmd_off),
    .hold_off(hold[`FLT_OC])
  );

  restart_ctrl #(.RETRY_CYCLES(RETRY_CYCLES)) ot_restart (
    .clk(clk),
    .reset_n(reset_n),
    .fault(st.flt_s2[`FLT_OT]),
    .retry_on(1'b1),
    .run_cmd(run_cmd),
    .cmd_off(cmd_off),
    .hold_off(hold[`FLT_OT])
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // synchronisers, register writes, faults, output gating, read answer
  always_comb begin
    next_st = st;
    next_st.ctl_s1 = remote_on_pin;
    next_st.ctl_s2 = st.ctl_s1;
    next_st.flt_s1 = {ot_fault_pin, oc_fault_pin, ov_fault_pin};
    next_st.flt_s2 = st.flt_s1;
    // remote off seen, cleared on the following on
    if (!st.ctl_s2) begin
      next_st.seen_off = 1'b1;
    end else begin
      next_st.seen_off = 1'b0;
    end
    if (wr) begin
      case (cmd_code)
        `CMD_RUN_CONTROL: begin
          next_st.run_on = cmd_wdata[`RUN_ON_BIT]; // [R11]
          if (cmd_wdata[`SRC_HI:`SRC_LO] != `SRC_BAD) begin // [R12] [R22]
            next_st.src = cmd_wdata[`SRC_HI:`SRC_LO];
          end
        end
        `CMD_OV_LIMIT: begin
          next_st.ov_lim = clamp(cmd_wdata, `OV_LIM_MIN,
                                 `OV_LIM_MAX); // [R2]
        end
        `CMD_OC_LIMIT: begin
          next_st.oc_lim = clamp(cmd_wdata, `OC_LIM_MIN,
                                 `OC_LIM_MAX); // [R3]
        end
        `CMD_OT_LIMIT: begin
          next_st.ot_lim = clamp(cmd_wdata, `OT_LIM_MIN,
                                 `OT_LIM_MAX); // [R4]
        end
        `CMD_OV_RESPONSE: begin
          next_st.ov_retry = rsp_retry(cmd_wdata[7:0], `OV_ACTION,
                                       st.ov_retry); // [R16] [R17]
        end
        `CMD_OC_RESPONSE: begin
          next_st.oc_retry = rsp_retry(cmd_wdata[7:0], `OC_ACTION,
                                       st.oc_retry); // [R18]
        end
        default: begin
        end
      endcase
    end
    // nonvolatile commands lock the output until power cycle
    if (cmd_strobe && (cmd_code == `CMD_NV_RESTORE ||
                       cmd_code == `CMD_NV_STORE)) begin // [R6] [R7]
      next_st.nv_locked = 1'b1;
    end
    // sticky faults, a new fault wins over a clear
    if (clr_any) begin // [R8] [R9]
      next_st.flags = st.flt_s2;
    end else begin
      next_st.flags = st.flags | st.flt_s2;
    end
    // gating waits for both control pin and run command
    next_st.out_on = st.run_on && st.ctl_s2 && !st.nv_locked &&
                     (hold == 3'h0); // [R13] [R14] [R6]
    next_st.rd_valid = rd;
    next_st.rd_data = 16'h0000;
    next_st.rd_count = `COUNT_NONE;
    if (rd) begin
      case (cmd_code)
        `CMD_RUN_CONTROL: begin
          next_st.rd_data = {8'h00, st.run_on, 1'b0, st.src, 4'h0}; // [R21]
          next_st.rd_count = `COUNT_BYTE;
        end
        `CMD_GATING: begin
          next_st.rd_data = `GATING_VALUE; // [R13] [R14] [R15]
          next_st.rd_count = `COUNT_BYTE;
        end
        `CMD_OV_LIMIT: begin
          next_st.rd_data = st.ov_lim;
          next_st.rd_count = `COUNT_WORD;
        end
        `CMD_OC_LIMIT: begin
          next_st.rd_data = st.oc_lim;
          next_st.rd_count = `COUNT_WORD;
        end
        `CMD_OT_LIMIT: begin
          next_st.rd_data = st.ot_lim;
          next_st.rd_count = `COUNT_WORD;
        end
        `CMD_OV_RESPONSE: begin
          next_st.rd_data = rsp_word(`OV_ACTION, st.ov_retry); // [R17]
          next_st.rd_count = `COUNT_BYTE;
        end
        `CMD_OC_RESPONSE: begin
          next_st.rd_data = rsp_word(`OC_ACTION, st.oc_retry); // [R18]
          next_st.rd_count = `COUNT_BYTE;
        end
        `CMD_FW_REV: begin
          next_st.rd_data = FW_REVISION;
          next_st.rd_count = `COUNT_FW; // [R10]
        end
        default: begin
        end
      endcase
    end
  end

  // state register, reset is the input power cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.run_on <= `RUN_RST_ON; // [R11]
      st.src <= `RUN_RST_SRC; // [R12]
      st.ov_lim <= `OV_LIM_RST;
      st.oc_lim <= `OC_LIM_RST;
      st.ot_lim <= `OT_LIM_RST;
      st.ov_retry <= `OV_RETRY_RST; // [R17]
      st.oc_retry <= `OC_RETRY_RST; // [R18]
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign rd_valid = st.rd_valid;
  assign rd_data = st.rd_data;
  assign rd_count = st.rd_count;
  assign output_on = st.out_on;
  assign setpoint_sel = st.src;
  assign fault_flags = st.flags;
  assign nv_locked = st.nv_locked;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence nv_access;
    cmd_strobe && (cmd_code == `CMD_NV_RESTORE ||
                   cmd_code == `CMD_NV_STORE);
  endsequence

  sequence output_down;
    nv_locked ##1 !output_on [*3];
  endsequence

  ov_clamp_a: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    (wr && cmd_code == `CMD_OV_LIMIT &&
     (cmd_wdata < `OV_LIM_MIN || cmd_wdata > `OV_LIM_MAX))
      |=> st.ov_lim == `OV_LIM_MIN)
    else $error("overvoltage limit not clamped to minimum");

  oc_clamp_a: assert property (@(posedge clk) disable iff (!reset_n) // [R3]
    (wr && cmd_code == `CMD_OC_LIMIT &&
     (cmd_wdata < `OC_LIM_MIN || cmd_wdata > `OC_LIM_MAX))
      |=> st.oc_lim == `OC_LIM_MIN)
    else $error("overcurrent limit not clamped to minimum");

  ot_clamp_a: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
    (wr && cmd_code == `CMD_OT_LIMIT && cmd_wdata >= `OT_LIM_MIN &&
     cmd_wdata <= `OT_LIM_MAX) |=> st.ot_lim == $past(cmd_wdata))
    else $error("in-range temperature limit not stored");

  nv_shutdown_a: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
    nv_access |=> output_down)
    else $error("output not shut after nonvolatile access");

  nv_stays_a: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
    nv_locked |=> nv_locked && !output_on)
    else $error("nonvolatile lock released");

  fault_sticky_a: assert property (@(posedge clk) // [R8]
    disable iff (!reset_n)
    (fault_flags[`FLT_OV] && !clr_any) |=> fault_flags[`FLT_OV])
    else $error("fault flag dropped without clear event");

  clear_cmd_a: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    (clr_cmd && st.flt_s2 == 3'h0) |=> fault_flags == 3'h0)
    else $error("clear faults left a flag set");

  fw_count_a: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
    (rd && cmd_code == `CMD_FW_REV) |=> rd_valid && rd_count == `COUNT_FW)
    else $error("firmware revision count not two");

  run_off_a: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
    (run_cmd && !cmd_wdata[`RUN_ON_BIT]) |=> ##1 !output_on)
    else $error("run bit clear did not turn output off");

  src_keep_a: assert property (@(posedge clk) disable iff (!reset_n) // [R22]
    (run_cmd && cmd_wdata[`SRC_HI:`SRC_LO] == `SRC_BAD)
      |=> setpoint_sel == $past(setpoint_sel))
    else $error("unsupported source code changed setpoint");

  gating_rd_a: assert property (@(posedge clk) disable iff (!reset_n) // [R15]
    (rd && cmd_code == `CMD_GATING) |=> rd_data == `GATING_VALUE)
    else $error("gating readback wrong");

  run_rsvd_a: assert property (@(posedge clk) disable iff (!reset_n) // [R21]
    (rd && cmd_code == `CMD_RUN_CONTROL) |=> rd_data[6] == 1'b0 &&
      rd_data[3:0] == 4'h0 && rd_data[15:8] == 8'h00)
    else $error("reserved run bits not zero");

endmodule : pm_cmd_bank

// [tb/pm_host.sv]
// Purpose: host model that issues commands to the register block
// Assumes: one command at a time, driven 1 ns after the rising edge
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps

module pm_host (
  input wire logic clk,
  output logic cmd_strobe,
  output logic [1:0] cmd_kind,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic [7:0] rd_count
);
  logic vld;
  logic [15:0] got;
  logic [7:0] cnt;

  // idle bus at time zero
  initial begin
    cmd_strobe = 1'b0;
    cmd_kind = 2'h3;
    cmd_code = 8'hff;
    cmd_wdata = 16'hffff;
  end

  // one strobe, answer captured while it stands after the taking edge
  task issue(input logic [1:0] k, input logic [7:0] c,
             input logic [15:0] d);
    @(posedge clk);
    #1;
    cmd_strobe = 1'b1;
    cmd_kind = k;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge clk);
    #1;
    vld = rd_valid;
    got = rd_data;
    cnt = rd_count;
    cmd_strobe = 1'b0;
    cmd_kind = ~k;
    cmd_code = ~c;
    cmd_wdata = ~d;
    @(posedge clk);
    #1;
  endtask : issue

  // limit write keeps the exponent read back first, except the overvoltage limit 0x40
  task set_limit(input logic [7:0] c, input logic [15:0] d);
    issue(2'h0, c, 16'h0000);
    if (c != 8'h40) begin
      d[15:11] = got[15:11];
    end
    issue(2'h1, c, d);
  endtask : set_limit
endmodule : pm_host

// [tb/test_pm_cmd_bank.sv]
// Purpose: self-checking bench of the command register block
// Assumes: 40 MHz clock, short retry time
// Notes: scenarios run in order; the nonvolatile one resets the block
`timescale 1ns/1ps
`include "pm_map.svh"

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end

module test_pm_cmd_bank;
  localparam int unsigned RETRY = 8;
  localparam logic [15:0] FW = 16'h2a5c; // arbitrary value
  localparam logic [7:0] LC [8] = '{8'h40, 8'h40, 8'h40, 8'h40,
    8'h46, 8'h46, 8'h4f, 8'h4f};
  localparam logic [15:0] LV [8] = '{16'h3700, 16'h3800, 16'h3900,
    16'h34cc, 16'hf141, 16'hf0ac, 16'h0118, 16'hf919};
  localparam logic [15:0] LE [8] = '{16'h3700, 16'h3800, 16'h34cd,
    16'h34cd, 16'hf0ac, 16'hf0ac, 16'hf918, 16'hf8f0};

  logic clk, reset_n, remote_on_pin, ov_fault_pin, oc_fault_pin;
  logic ot_fault_pin, cmd_strobe, rd_valid, output_on, nv_locked;
  logic [1:0] cmd_kind, setpoint_sel;
  logic [7:0] cmd_code, rd_count;
  logic [15:0] cmd_wdata, rd_data;
  logic [2:0] fault_flags;
  int mismatches = 0;
  int compares = 0;

  // ----------------------------------------------------------------
  // block, host and clock
  // ----------------------------------------------------------------
  pm_cmd_bank #(.RETRY_CYCLES(RETRY), .FW_REVISION(FW)) dut_u (
    .clk(clk), .reset_n(reset_n), .cmd_strobe(cmd_strobe),
    .cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .remote_on_pin(remote_on_pin), .ov_fault_pin(ov_fault_pin),
    .oc_fault_pin(oc_fault_pin), .ot_fault_pin(ot_fault_pin),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_count(rd_count),
    .output_on(output_on), .setpoint_sel(setpoint_sel),
    .fault_flags(fault_flags), .nv_locked(nv_locked));

  pm_host host_u (
    .clk(clk), .cmd_strobe(cmd_strobe), .cmd_kind(cmd_kind),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_count(rd_count));

  // free-running clock
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task wr(input logic [7:0] c, input logic [15:0] d);
    host_u.issue(`KIND_WRITE, c, d);
  endtask : wr

  task rd(input logic [7:0] c, input logic [15:0] d, input logic [7:0] n);
    host_u.issue(`KIND_READ, c, 16'h0000);
    `CHK(host_u.vld, 1'b1)
    `CHK(host_u.got, d)
    `CHK(host_u.cnt, n)
  endtask : rd

  task conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_defaults;
    `CHK(output_on, 1'b1)
    rd(`CMD_RUN_CONTROL, 16'h0080, `COUNT_BYTE);
    rd(`CMD_GATING, `GATING_VALUE, `COUNT_BYTE);
    rd(`CMD_OV_RESPONSE, 16'h0080, `COUNT_BYTE);
    rd(`CMD_OC_RESPONSE, 16'h00f8, `COUNT_BYTE);
    rd(`CMD_OV_LIMIT, `OV_LIM_RST, `COUNT_WORD);
    rd(`CMD_OC_LIMIT, `OC_LIM_RST, `COUNT_WORD);
    rd(`CMD_OT_LIMIT, `OT_LIM_RST, `COUNT_WORD);
    rd(`CMD_FW_REV, FW, `COUNT_FW);
    rd(8'h20, 16'h0000, `COUNT_NONE); // unmapped
  endtask : t_defaults

  task t_limits;
    for (int i = 0; i < 8; i++) begin
      host_u.set_limit(LC[i], LV[i]);
      rd(LC[i], LE[i], `COUNT_WORD);
    end
  endtask : t_limits

  task t_run;
    wr(`CMD_RUN_CONTROL, 16'h0010);
    settle(3);
    `CHK(setpoint_sel, 2'h1)
    `CHK(output_on, 1'b0)
    wr(`CMD_RUN_CONTROL, 16'h00e0);
    rd(`CMD_RUN_CONTROL, 16'h00a0, `COUNT_BYTE);
    wr(`CMD_RUN_CONTROL, 16'h00ff);
    rd(`CMD_RUN_CONTROL, 16'h00a0, `COUNT_BYTE);
    `CHK(setpoint_sel, 2'h2)
    wr(`CMD_RUN_CONTROL, 16'h0080);
    settle(3);
    `CHK(setpoint_sel, 2'h0)
    `CHK(output_on, 1'b1)
    wr(`CMD_GATING, 16'h0000);
    rd(`CMD_GATING, `GATING_VALUE, `COUNT_BYTE);
  endtask : t_run

  task t_response;
    wr(`CMD_OV_RESPONSE, 16'h00b8);
    rd(`CMD_OV_RESPONSE, 16'h00b8, `COUNT_BYTE);
    wr(`CMD_OV_RESPONSE, 16'h0090);
    rd(`CMD_OV_RESPONSE, 16'h00b8, `COUNT_BYTE);
    wr(`CMD_OV_RESPONSE, 16'h00c0);
    rd(`CMD_OV_RESPONSE, 16'h00b8, `COUNT_BYTE);
    wr(`CMD_OC_RESPONSE, 16'h00c7);
    rd(`CMD_OC_RESPONSE, 16'h00c0, `COUNT_BYTE);
    wr(`CMD_OC_RESPONSE, 16'h00b8);
    rd(`CMD_OC_RESPONSE, 16'h00c0, `COUNT_BYTE);
  endtask : t_response

  task t_latch;
    oc_fault_pin = 1'b1;
    settle(8);
    `CHK(fault_flags, 3'h2)
    `CHK(output_on, 1'b0)
    oc_fault_pin = 1'b0;
    settle(40);
    `CHK(output_on, 1'b0)
    `CHK(fault_flags, 3'h2)
    wr(`CMD_RUN_CONTROL, 16'h0080);
    settle(4);
    `CHK(output_on, 1'b1)
    host_u.issue(`KIND_SEND, `CMD_CLEAR_FAULTS, 16'h0000);
    `CHK(fault_flags, 3'h0)
  endtask : t_latch

  task t_retry;
    ov_fault_pin = 1'b1;
    ot_fault_pin = 1'b1;
    settle(8);
    `CHK(fault_flags, 3'h5)
    `CHK(output_on, 1'b0)
    ov_fault_pin = 1'b0;
    ot_fault_pin = 1'b0;
    settle(40);
    `CHK(output_on, 1'b1)
    `CHK(fault_flags, 3'h5)
    remote_on_pin = 1'b0;
    settle(6);
    remote_on_pin = 1'b1;
    settle(8);
    `CHK(fault_flags, 3'h0)
  endtask : t_retry

  task t_nv;
    for (int i = 0; i < 2; i++) begin
      host_u.issue(i[1:0], i ? `CMD_NV_STORE : `CMD_NV_RESTORE, 16'h0000);
      `CHK(host_u.cnt, `COUNT_NONE)
      settle(4);
      `CHK(nv_locked, 1'b1)
      `CHK(output_on, 1'b0)
      wr(`CMD_RUN_CONTROL, 16'h0080);
      settle(4);
      `CHK(output_on, 1'b0)
      reset_n = 1'b0;
      settle(2);
      reset_n = 1'b1;
      settle(6);
      `CHK(nv_locked, 1'b0)
      `CHK(output_on, 1'b1)
    end
  endtask : t_nv

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    remote_on_pin = 1'b1;
    ov_fault_pin = 1'b0;
    oc_fault_pin = 1'b0;
    ot_fault_pin = 1'b0;
    settle(16);
    reset_n = 1'b1;
    settle(6);
    t_defaults();
    t_limits();
    t_run();
    t_response();
    t_latch();
    t_retry();
    t_nv();
    conclude();
  end

  // cut a hang short
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    $display("MISMATCH %0t watchdog expired", $time);
    conclude();
  end
endmodule : test_pm_cmd_bank
